// >>> tmr_cnt_cell.sv
// tmr_cnt_cell: one counter with zeroing, write, clear and step priority
module tmr_cnt_cell #(
    parameter int W    = 16,
    parameter bit DOWN = 1'b0
) (
    input  wire logic         clock,
    input  wire logic         rst_b,
    input  wire logic         zap,
    input  wire logic         load,
    input  wire logic [W-1:0] loadVal,
    input  wire logic         clr,
    input  wire logic         step,
    output logic [W-1:0]      cnt
);

    // ========================================================
    // counter update
    // zap beats a write so an underflow halt keeps zero
    always_ff @(posedge clock) begin
        if (!rst_b || zap) begin
            cnt <= '0;
        end else if (load) begin
            cnt <= loadVal;              // a write beats clear and step
        end else if (clr) begin
            cnt <= '0;
        end else if (step) begin
            cnt <= DOWN ? cnt - 1'b1 : cnt + 1'b1;
        end
    end

endmodule : tmr_cnt_cell

// >>> tmr_core.sv
// tmr_core: timer channels with write, clear and flag contention
//
// Chosen here: the placing of the registers and the APB register port.
module tmr_core
    import tmr_pkg::*;
#(
    parameter int CW = 16
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire tmr_apb_s         apb,
    output logic                  pready,
    output logic                  pslverr,
    output logic [31:0]           prdata,
    input  wire logic             capPin,
    input  wire logic             evtPin,
    input  wire logic [NFLAG-1:0] dmaClr,
    input  wire logic             standby,
    output logic                  pwmOut,
    output logic                  channel1OutputPin,
    output logic                  intervalIrq,
    output logic                  adcStart
);

    // ========================================================
    // state
    logic [NRUN-1:0]  runBits;
    logic             downRun;
    logic [7:0]       psc;
    logic [7:0]       pscCnt;
    logic [5:0]       settle;
    logic [1:0]       ctrl;
    logic [15:0]      itv;
    logic [CW-1:0]    period;
    logic [CW-1:0]    dutyBuf;
    logic [CW-1:0]    duty;
    logic [CW-1:0]    capHold;
    logic [CW-1:0]    frc;
    logic [CW-1:0]    pwmCnt;
    logic [CW-1:0]    downCnt;
    logic [CW-1:0]    evtCnt;
    logic [NFLAG-1:0] flags;
    logic [1:0]       capSync;
    logic [1:0]       evtSync;
    logic             capPrev;
    logic             evtPrev;
    logic [7:0]       prevWatch;
    logic             stbyPrev;

    // ========================================================
    // bus decode; a write lands at the edge that ends the access
    logic          wrAcc;
    logic          mapped;
    logic [CW-1:0] wd;
    logic          wrStart, wrDstart, wrPsc, wrCtrl, wrItv, wrFrc;
    logic          wrPwm, wrPer, wrDbuf, wrDuty, wrDown, wrEvt, wrFlags;

    assign wrAcc    = apb.psel && apb.penable && apb.pwrite;
    assign wd       = apb.pwdata[CW-1:0];
    assign mapped   = (apb.paddr[1:0] == 2'h0) && (apb.paddr <= OFS_STATUS);
    assign pready   = 1'b1;
    assign pslverr  = apb.psel && apb.penable && !mapped;
    assign wrStart  = wrAcc && (apb.paddr == OFS_START);
    assign wrDstart = wrAcc && (apb.paddr == OFS_DSTART);
    assign wrPsc    = wrAcc && (apb.paddr == OFS_PSC);
    assign wrCtrl   = wrAcc && (apb.paddr == OFS_CTRL);
    assign wrItv    = wrAcc && (apb.paddr == OFS_ITV);
    assign wrFrc    = wrAcc && (apb.paddr == OFS_FRC);
    assign wrPwm    = wrAcc && (apb.paddr == OFS_PWMCNT);
    assign wrPer    = wrAcc && (apb.paddr == OFS_PERIOD);
    assign wrDbuf   = wrAcc && (apb.paddr == OFS_DBUF);
    assign wrDuty   = wrAcc && (apb.paddr == OFS_DUTY);
    assign wrDown   = wrAcc && (apb.paddr == OFS_DOWN);
    assign wrEvt    = wrAcc && (apb.paddr == OFS_EVT);
    assign wrFlags  = wrAcc && (apb.paddr == OFS_FLAGS);

    // ========================================================
    // pin synchronisers, edges taken from the second stage only
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            capSync <= 2'h0;
            evtSync <= 2'h0;
            capPrev <= 1'b0;
            evtPrev <= 1'b0;
        end else begin
            capSync <= {capSync[0], capPin};
            evtSync <= {evtSync[0], evtPin};
            capPrev <= capSync[1];
            evtPrev <= evtSync[1];
        end
    end

    // ========================================================
    // events
    logic tick, frcStep, frcOvf, pwmStep, pwmMatch, dutyMatch;
    logic downStep, downUnder, evtStep, capHit;

    assign tick      = (pscCnt == psc);
    assign frcStep   = runBits[RUN_FRC] && tick;
    assign frcOvf    = frcStep && (frc == '1);
    assign pwmStep   = runBits[RUN_PWM] && tick;
    assign pwmMatch  = pwmStep && (pwmCnt == period);
    assign dutyMatch = pwmStep && (pwmCnt == duty);
    assign downStep  = downRun && tick;
    assign downUnder = downStep && (downCnt == '0);
    assign evtStep   = runBits[RUN_EVT] && evtSync[1] && !evtPrev;
    assign capHit    = ctrl[CTRL_CAP] && capSync[1] && !capPrev;

    // ========================================================
    // prescaler; a write restarts the settle count software waits on
    always_ff @(posedge clock) begin
        if (!rst_b || standby) begin
            psc    <= RST_PSC;
            pscCnt <= 8'h00;
            settle <= 6'h00;
        end else begin
            if (wrPsc) begin
                psc <= apb.pwdata[7:0];
            end
            pscCnt <= tick ? 8'h00 : pscCnt + 8'h01;
            if (wrPsc) begin
                settle <= 6'h00;
            end else if (settle != PSC_SETTLE) begin
                settle <= settle + 6'h01;
            end
        end
    end

    // ========================================================
    // configuration registers
    // mode changes while running are not guarded; software keeps order
    always_ff @(posedge clock) begin
        if (!rst_b || standby) begin
            runBits <= '0;
            ctrl    <= 2'h0;
            itv     <= 16'h0000;
            period  <= rst_b ? '0 : RST_PERIOD[CW-1:0]; // standby zeroes
            dutyBuf <= '0;
        end else begin
            if (wrStart) begin
                runBits <= apb.pwdata[NRUN-1:0];
            end
            if (wrCtrl) begin
                ctrl <= apb.pwdata[1:0];
            end
            if (wrItv) begin
                itv <= apb.pwdata[15:0];
            end
            if (wrPer) begin
                period <= wd;
            end
            if (wrDbuf) begin
                dutyBuf <= wd;
            end
        end
    end

    // ========================================================
    // down start bit: software can only set it, underflow clears it
    always_ff @(posedge clock) begin
        if (!rst_b || standby) begin
            downRun <= 1'b0;
        end else if (downUnder) begin
            downRun <= 1'b0;
        end else if (wrDstart && apb.pwdata[0]) begin
            downRun <= 1'b1;
        end
    end

    // ========================================================
    // counters
    // write beats step in cell
    tmr_cnt_cell #(.W(CW), .DOWN(1'b0)) u_frc (
        .clock   (clock),
        .rst_b   (rst_b),
        .zap     (standby),
        .load    (wrFrc),
        .loadVal (wd),
        .clr     (1'b0),
        .step    (frcStep),
        .cnt     (frc)
    );

    tmr_cnt_cell #(.W(CW), .DOWN(1'b0)) u_pwm (
        .clock   (clock),
        .rst_b   (rst_b),
        .zap     (standby),
        .load    (wrPwm),
        .loadVal (wd),
        .clr     (pwmMatch),
        .step    (pwmStep),
        .cnt     (pwmCnt)
    );

    tmr_cnt_cell #(.W(CW), .DOWN(1'b1)) u_down (
        .clock   (clock),
        .rst_b   (rst_b),
        .zap     (standby || downUnder),
        .load    (wrDown),
        .loadVal (wd),
        .clr     (1'b0),
        .step    (downStep),
        .cnt     (downCnt)
    );

    tmr_cnt_cell #(.W(CW), .DOWN(1'b0)) u_evt (
        .clock   (clock),
        .rst_b   (rst_b),
        .zap     (standby),
        .load    (wrEvt),
        .loadVal (wd),
        .clr     (1'b0),
        .step    (evtStep),
        .cnt     (evtCnt)
    );

    // ========================================================
    // duty compare and capture holding
    always_ff @(posedge clock) begin
        if (!rst_b || standby) begin
            duty    <= '0;
            capHold <= '0;
        end else begin
            if (wrDuty) begin
                duty <= wd;
            end else if (pwmMatch) begin
                duty <= dutyBuf;
            end
            if (capHit) begin
                capHold <= frc;
            end
        end
    end

    // ========================================================
    // status flags
    logic [NFLAG-1:0] flagSet, cpuClr, clrVec;

    assign flagSet = {downUnder, dutyMatch, pwmMatch, capHit, frcOvf};
    assign cpuClr  = wrFlags ? ~apb.pwdata[NFLAG-1:0] : '0;
    assign clrVec  = cpuClr | (dmaClr & DMA_MASK);

    tmr_flag_bank #(.N(NFLAG)) u_flags (
        .clock (clock),
        .rst_b (rst_b),
        .zap   (standby),
        .set   (flagSet),
        .clr   (clrVec),
        .flag  (flags)
    );

    // ========================================================
    // waveform outputs hold their level while stopped
    always_ff @(posedge clock) begin
        stbyPrev <= rst_b && standby;
        if (!rst_b || standby) begin
            pwmOut <= 1'b0;
        end else if (pwmMatch && ctrl[CTRL_PWM]) begin
            pwmOut <= 1'b1;
        end else if (dutyMatch && ctrl[CTRL_PWM]) begin
            pwmOut <= 1'b0;
        end
        if (!rst_b || (stbyPrev && !standby)) begin
            channel1OutputPin <= 1'b0;
        end else if (frcOvf && !standby) begin
            channel1OutputPin <= !channel1OutputPin;
        end
    end

    // ========================================================
    // interval detect watches the counter value, so a software write
    // is seen too, also while the counter is halted
    logic [7:0] itvRise;

    assign itvRise = frc[ITV_HI:ITV_LO] & ~prevWatch;

    always_ff @(posedge clock) begin
        if (!rst_b || standby) begin
            prevWatch   <= 8'h00;
            intervalIrq <= 1'b0;
            adcStart    <= 1'b0;
        end else begin
            prevWatch   <= frc[ITV_HI:ITV_LO];
            intervalIrq <= |(itvRise & itv[7:0]);
            adcStart    <= |(itvRise & itv[15:8]);
        end
    end

    // ========================================================
    // read data latched in setup so the access phase reads a flop
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (apb.psel && !apb.penable) begin
            case (apb.paddr)
                OFS_START:  prdata <= 32'(runBits);
                OFS_DSTART: prdata <= 32'(downRun);
                OFS_PSC:    prdata <= 32'(psc);
                OFS_CTRL:   prdata <= 32'(ctrl);
                OFS_ITV:    prdata <= 32'(itv);
                OFS_FRC:    prdata <= 32'(frc);
                OFS_PWMCNT: prdata <= 32'(pwmCnt);
                OFS_PERIOD: prdata <= 32'(period);
                OFS_DBUF:   prdata <= 32'(dutyBuf);
                OFS_DUTY:   prdata <= 32'(duty);
                OFS_DOWN:   prdata <= 32'(downCnt);
                OFS_EVT:    prdata <= 32'(evtCnt);
                OFS_CAPT:   prdata <= 32'(capHold);
                OFS_FLAGS:  prdata <= 32'(flags);
                OFS_STATUS: prdata <= 32'(settle == PSC_SETTLE);
                default:    prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ========================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b || standby);

    sequence s_zero_wr;
        wrDown && (wd == '0) && downRun && !downUnder;
    endsequence

    property p_wr_beats_clear;
        wrPwm && pwmMatch |=> pwmCnt == $past(wd);
    endproperty
    a_wr_beats_clear: assert property (p_wr_beats_clear)
        else $error("pwm counter write lost to match clear");

    property p_match_flags;
        pwmMatch && !clrVec[FL_PER] |=> flags[FL_PER];
    endproperty
    a_match_flags: assert property (p_match_flags)
        else $error("period match did not set its flag");

    property p_wr_beats_step;
        wrEvt && evtStep |=> evtCnt == $past(wd);
    endproperty
    a_wr_beats_step: assert property (p_wr_beats_step)
        else $error("event counter write lost to step");

    property p_ovf_keep;
        wrFrc && frcOvf && !clrVec[FL_OVF]
            |=> frc == $past(wd) && flags[FL_OVF];
    endproperty
    a_ovf_keep: assert property (p_ovf_keep)
        else $error("overflow write not kept or flag not set");

    property p_clr_wins;
        frcOvf && cpuClr[FL_OVF] |=> !flags[FL_OVF];
    endproperty
    a_clr_wins: assert property (p_clr_wins)
        else $error("overflow set beat software clear");

    property p_duty_cpu;
        wrDuty && pwmMatch |=> duty == $past(wd);
    endproperty
    a_duty_cpu: assert property (p_duty_cpu)
        else $error("buffer transfer beat cpu duty write");

    property p_dma_wins;
        capHit && dmaClr[FL_CAP] |=> !flags[FL_CAP];
    endproperty
    a_dma_wins: assert property (p_dma_wins)
        else $error("capture set beat dma clear");

    property p_zero_keeps_run;
        s_zero_wr |=> downRun;
    endproperty
    a_zero_keeps_run: assert property (p_zero_keeps_run)
        else $error("zero write stopped down counter at once");

    property p_under_halts;
        downUnder && !clrVec[FL_UND]
            |=> !downRun && downCnt == '0 && flags[FL_UND];
    endproperty
    a_under_halts: assert property (p_under_halts)
        else $error("underflow did not halt down counter");

    property p_capture;
        capHit && !clrVec[FL_CAP] |=> capHold == $past(frc) && flags[FL_CAP];
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture did not copy counter");

    property p_under_keeps0;
        wrDown && downUnder |=> downCnt == '0;
    endproperty
    a_under_keeps0: assert property (p_under_keeps0)
        else $error("write beat underflow zero");

    property p_start_loses;
        wrDstart && apb.pwdata[0] && downUnder |=> !downRun;
    endproperty
    a_start_loses: assert property (p_start_loses)
        else $error("start write beat underflow clear");

    property p_stop_holds;
        !runBits[RUN_FRC] && !wrFrc |=> frc == $past(frc);
    endproperty
    a_stop_holds: assert property (p_stop_holds)
        else $error("stopped counter changed");

    property p_itv_write;
        wrFrc && |(wd[ITV_HI:ITV_LO] & ~frc[ITV_HI:ITV_LO] & itv[7:0])
            |-> ##2 intervalIrq;
    endproperty
    a_itv_write: assert property (p_itv_write)
        else $error("interval rise from write not signalled");

endmodule : tmr_core

// >>> tmr_core_tb_top.sv
// tmr_core_tb_top: self-checking bench for the timer contention core
module tmr_core_tb_top
    import tmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic             clock, rst_b, standby, pready, pslverr;
    logic             capPin, evtPin, pwmOut, ch1Pin, irq, adc;
    tmr_apb_s         apb;
    logic [31:0]      prdata;
    logic [NFLAG-1:0] dmaClr;
    logic [32:0]      q[$];
    logic [15:0]      v;
    int               bad_count, compares, irqs, adcs, seed;
    // ========================================================
    // clock and instances
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    tmr_core u_tmr_core (.clock(clock), .rst_b(rst_b), .apb(apb),
        .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .capPin(capPin), .evtPin(evtPin), .dmaClr(dmaClr),
        .standby(standby), .pwmOut(pwmOut),
        .channel1OutputPin(ch1Pin), .intervalIrq(irq), .adcStart(adc));
    tmr_pin_model pins (.clock(clock), .capPin(capPin),
        .evtPin(evtPin), .dmaClr(dmaClr));
    // ========================================================
    // checking and closing
    task automatic cmp(input string n, input logic [32:0] e, s);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : cmp
    task automatic complete_run();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    // oldest note meets each read answer; pulses are tallied
    always @(posedge clock) begin
        if (rst_b && apb.psel && apb.penable && !apb.pwrite && pready)
            cmp("read", q.pop_front(), {pslverr, prdata});
        if (irq === 1'b1) irqs++;
        if (adc === 1'b1) adcs++;
    end
    // ========================================================
    // apb master: request held until pready, released by idle
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        if (!w) q.push_back(e);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock) apb.penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 33'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, {1'b0, e});
    endtask : rd
    task automatic idle(input int n);
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        repeat (n) @(posedge clock);
    endtask : idle
    // a hung handshake ends the run as a failure
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        complete_run();
    end
    // ========================================================
    // main sequence
    initial begin
        {rst_b, standby, apb, bad_count, compares, irqs, adcs} = '0;
        seed = 57;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        rd(OFS_PERIOD, {16'h0, RST_PERIOD});
        bus(1'b0, 8'h3C, 32'h0, {1'b1, 32'h0});
        // settle wait after a prescaler write
        wr(OFS_PSC, 32'h0);
        rd(OFS_STATUS, 32'h0);
        idle(32);
        rd(OFS_STATUS, 32'h1);
        // writes racing a count step and an event step
        wr(OFS_START, 32'h5);
        fork
            pins.evt_edge();
            begin
                idle(2);
                wr(OFS_EVT, 32'h5555);
            end
        join
        rd(OFS_EVT, 32'h5555);
        repeat (4) begin
            v = 16'($random(seed)) & 16'h7FFF;
            wr(OFS_FRC, {16'h0, v});
            rd(OFS_FRC, {16'h0, v});
        end
        wr(OFS_FRC, 32'hFFFE);
        wr(OFS_FRC, 32'h5555);
        rd(OFS_FRC, 32'h5555);
        cmp("ch1Pin", 33'h1, {32'h0, ch1Pin});
        rd(OFS_FLAGS, 32'h1);
        wr(OFS_FRC, 32'hFFFE);
        wr(OFS_FLAGS, 32'h0);
        rd(OFS_FLAGS, 32'h0);
        wr(OFS_START, 32'h0);
        wr(OFS_CTRL, 32'h3);
        wr(OFS_FRC, 32'h1234);
        idle(1);
        pins.cap_edge();
        idle(6);
        rd(OFS_FRC, 32'h1234);
        rd(OFS_CAPT, 32'h1234);
        rd(OFS_FLAGS, 32'h2);
        idle(1);
        pins.dma_pulse(5'h02);
        rd(OFS_FLAGS, 32'h0);
        // dma clear lands on the capture set edge
        fork
            pins.cap_edge();
            begin
                idle(2);
                pins.dma_pulse(5'h02);
            end
        join
        rd(OFS_FLAGS, 32'h0);
        // zero write halts at next underflow
        wr(OFS_DOWN, 32'h00FF);
        wr(OFS_DSTART, 32'h1);
        wr(OFS_DOWN, 32'h0);
        rd(OFS_DSTART, 32'h1);
        rd(OFS_DSTART, 32'h0);
        rd(OFS_FLAGS, 32'h10);
        wr(OFS_FLAGS, 32'h0);
        // underflow beats counter and start writes
        for (int k = 0; k < 2; k++) begin
            wr(OFS_DOWN, 32'h00FF);
            wr(OFS_DSTART, 32'h1);
            wr(OFS_DOWN, 32'h1);
            wr(k ? OFS_DSTART : OFS_DOWN, k ? 32'h1 : 32'h5555);
            rd(OFS_DOWN, 32'h0);
            rd(OFS_DSTART, 32'h0);
            rd(OFS_FLAGS, 32'h10);
            wr(OFS_FLAGS, 32'h0);
        end
        wr(OFS_PERIOD, 32'h10);
        wr(OFS_DBUF, 32'hAAAA);
        wr(OFS_DUTY, 32'h800);
        wr(OFS_START, 32'h2);
        wr(OFS_PWMCNT, 32'hF);
        wr(OFS_PWMCNT, 32'h777);
        rd(OFS_PWMCNT, 32'h777);
        rd(OFS_FLAGS, 32'h4);
        cmp("pwmOut", 33'h1, {32'h0, pwmOut});
        wr(OFS_PWMCNT, 32'hF);
        wr(OFS_DUTY, 32'h5555);
        rd(OFS_DUTY, 32'h5555);
        wr(OFS_START, 32'h0);
        cmp("pwmOut", 33'h1, {32'h0, pwmOut});
        wr(OFS_FRC, 32'h0);
        wr(OFS_ITV, 32'h0201);
        wr(OFS_FRC, 32'h00C0);
        idle(4);
        cmp("irq", 33'(1), 33'(irqs));
        cmp("adc", 33'(1), 33'(adcs));
        // overflow raises the channel 1 pin before standby
        wr(OFS_START, 32'h1);
        wr(OFS_FRC, 32'hFFFF);
        wr(OFS_START, 32'h0);
        // standby clears, writes lost, pin clears on exit
        standby <= 1'b1;
        idle(2);
        wr(OFS_PERIOD, 32'h55);
        rd(OFS_PERIOD, 32'h0);
        rd(OFS_FRC, 32'h0);
        cmp("pwmOut", 33'h0, {32'h0, pwmOut});
        cmp("ch1Pin", 33'h1, {32'h0, ch1Pin});
        standby <= 1'b0;
        idle(2);
        cmp("ch1Pin", 33'h0, {32'h0, ch1Pin});
        complete_run();
    end
endmodule : tmr_core_tb_top

// >>> tmr_flag_bank.sv
// tmr_flag_bank: sticky status flags where a clear beats a set
module tmr_flag_bank #(
    parameter int N = 5
) (
    input  wire logic         clock,
    input  wire logic         rst_b,
    input  wire logic         zap,
    input  wire logic [N-1:0] set,
    input  wire logic [N-1:0] clr,
    output logic [N-1:0]      flag
);

    // ========================================================
    // flag update
    // events on a set flag are not queued; a clear in the same
    // cycle as an event wins, so the event is dropped
    always_ff @(posedge clock) begin
        if (!rst_b || zap) begin
            flag <= '0;
        end else begin
            flag <= (flag | set) & ~clr;
        end
    end

endmodule : tmr_flag_bank

// >>> tmr_pin_model.sv
// tmr_pin_model: capture pin and dma clear source facing the timer
module tmr_pin_model (
    input  wire logic  clock,
    output logic       capPin,
    output logic       evtPin,
    output logic [4:0] dmaClr
);
    timeunit 1ns;
    timeprecision 100ps;
    // ========================================================
    // pins rest low; the event pin only gives single pulses
    initial begin
        capPin = 1'b0;
        evtPin = 1'b0;
        dmaClr = 5'h00;
    end
    // held four clocks so the synchroniser cannot miss the edge
    task automatic cap_edge();
        @(posedge clock) capPin <= 1'b1;
        repeat (4) @(posedge clock);
        capPin <= 1'b0;
    endtask : cap_edge
    // one event pulse, two clocks high so the synchroniser takes it
    task automatic evt_edge();
        @(posedge clock) evtPin <= 1'b1;
        repeat (2) @(posedge clock);
        evtPin <= 1'b0;
    endtask : evt_edge
    // one-cycle clear, as the dma controller issues it
    task automatic dma_pulse(input logic [4:0] m);
        @(posedge clock) dmaClr <= m;
        @(posedge clock) dmaClr <= 5'h00;
    endtask : dma_pulse
endmodule : tmr_pin_model

// >>> tmr_pkg.sv
// tmr_pkg: register offsets, field positions, reset values and carriers
package tmr_pkg;

    // ========================================================
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_START  = 8'h00; // timer_start_bits
    localparam logic [7:0] OFS_DSTART = 8'h04; // down_start_bits
    localparam logic [7:0] OFS_PSC    = 8'h08; // prescaler_setting
    localparam logic [7:0] OFS_CTRL   = 8'h0C; // timer_control_setting
    localparam logic [7:0] OFS_ITV    = 8'h10; // interval_request_select
    localparam logic [7:0] OFS_FRC    = 8'h14; // free_run_counter
    localparam logic [7:0] OFS_PWMCNT = 8'h18; // pwm channel counter
    localparam logic [7:0] OFS_PERIOD = 8'h1C; // period_compare
    localparam logic [7:0] OFS_DBUF   = 8'h20; // duty_buffer
    localparam logic [7:0] OFS_DUTY   = 8'h24; // duty compare
    localparam logic [7:0] OFS_DOWN   = 8'h28; // down_counter
    localparam logic [7:0] OFS_EVT    = 8'h2C; // event_counter
    localparam logic [7:0] OFS_CAPT   = 8'h30; // capture_holding
    localparam logic [7:0] OFS_FLAGS  = 8'h34; // timer_flag_register
    localparam logic [7:0] OFS_STATUS = 8'h38; // prescaler settle state

    // ========================================================
    // field positions
    localparam int RUN_FRC  = 0;
    localparam int RUN_PWM  = 1;
    localparam int RUN_EVT  = 2;
    localparam int NRUN     = 3;
    localparam int CTRL_CAP = 0;
    localparam int CTRL_PWM = 1;
    localparam int FL_OVF   = 0; // overflow_flag
    localparam int FL_CAP   = 1; // capture_flag
    localparam int FL_PER   = 2; // period_match_flag
    localparam int FL_DUTY  = 3; // general_match_flag on duty
    localparam int FL_UND   = 4; // underflow_flag
    localparam int NFLAG    = 5;
    localparam int ITV_LO   = 6;
    localparam int ITV_HI   = 13;

    // flags that the dma controller may clear
    localparam logic [NFLAG-1:0] DMA_MASK = 5'h06;

    // ========================================================
    // reset values and counts
    localparam logic [7:0]  RST_PSC    = 8'h00;
    localparam logic [15:0] RST_PERIOD = 16'hFFFF;
    localparam logic [5:0]  PSC_SETTLE = 6'h20;

    // ========================================================
    // apb request carrier
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } tmr_apb_s;

endpackage : tmr_pkg
